// ===== hdl/mtdc_pkg.sv
package mtdc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TURNAROUND = 8'h4c;
  localparam logic [7:0] OFS_DECAY = 8'h50;
  localparam logic [7:0] OFS_LOWTOP = 8'h6c;
  localparam logic [7:0] OFS_RANGE0 = 8'h80;
  localparam logic [7:0] OFS_RANGE1 = 8'h84;
  localparam logic [7:0] OFS_RANGE2 = 8'h88;

  // ----------------------------------------------------------------
  // Command spacing fields
  // ----------------------------------------------------------------
  localparam int GAP_W = 4;
  localparam int WR_RD_OTHER_LSB = 16;
  localparam int WR_RD_OTHER_W = 3;
  localparam int RD_WR_LSB = 12;
  localparam int WR_RD_SAME_LSB = 8;
  localparam int RD_RD_OTHER_LSB = 4;
  localparam int WR_WR_LSB = 0;
  localparam logic [18:0] TURNAROUND_RST = 19'h00000;
  localparam int NUM_GAPS = 5;
  localparam int GI_WR_RD_OTHER = 0;
  localparam int GI_RD_WR = 1;
  localparam int GI_WR_RD_SAME = 2;
  localparam int GI_RD_RD_OTHER = 3;
  localparam int GI_WR_WR = 4;

  // ----------------------------------------------------------------
  // Error decay
  // ----------------------------------------------------------------
  localparam int DECAY_PRESCALE = 32768;
  localparam int PRESCALE_W = 15;
  localparam logic [31:0] DECAY_RST = 32'h00000000;
  localparam int ERRCNT_W = 8;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int LOWTOP_LSB = 12;
  localparam int LOWTOP_W = 4;
  localparam logic [3:0] LOWTOP_RST = 4'h1;
  localparam logic [3:0] LOWTOP_ILLEGAL = 4'h0;
  localparam int NUM_RANGES = 3;
  localparam int LIMIT_LSB = 4;
  localparam int LIMIT_W = 8;
  localparam int BRANCH_ZERO_MEMBER_BIT = 0;
  localparam int BRANCH_ONE_MEMBER_BIT = 1;
  localparam logic [8:0] GAP_BASE_4G = 9'h010;
  localparam int ADDR_W = 36;
  localparam int WAY_SENSE_BIT = 6;
  localparam int VGA_LSB = 17;
  localparam logic [18:0] VGA_PAGE = 19'h00005;
  localparam int MOD_W = 2;
  localparam int RANK_W = 3;

endpackage

// ===== hdl/mtdc_gap_timer.sv
`timescale 1ns/1ps
module mtdc_gap_timer
  import mtdc_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic nrst, // Sync reset, low
  input wire logic load, // Qualifying command issued
  input wire logic [GAP_W-1:0] loadVal, // Programmed spacing
  output logic busy // Dependent command held back
);

  typedef struct packed {
    logic [GAP_W-1:0] cnt;
  } mtdc_gap_st_t;

  mtdc_gap_st_t s_reg;
  mtdc_gap_st_t s_next;

  // Down-counter, expires when one cycle is left
  always_comb
  begin
    s_next = s_reg;
    if (load)
      s_next.cnt = loadVal;
    else if (s_reg.cnt != '0)
      s_next.cnt = s_reg.cnt - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign busy = (s_reg.cnt > 4'h1);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_timer_loads: assert property (@(posedge clk) disable iff (!nrst)
    load && loadVal > 4'h1 |=> busy)
    else $error("spacing timer not busy after load");
  a_timer_expires: assert property (@(posedge clk) disable iff (!nrst)
    load && loadVal == 4'h3 ##1 !load ##1 !load |=> !busy)
    else $error("spacing timer held too long");

endmodule

// ===== hdl/mtdc_top.sv
`timescale 1ns/1ps
// How it works
// - Write to read, other rank gap
// - Read to write, same module gap
// - Write to read, same rank gap
// - Read to read, other rank gap
// - Write to write, same module gap
// - Period counter steps every 32768 cycles
// - Threshold hit decrements non-zero error counts
// - Period counter clears on reset, threshold
// - Low top compares address bits 31:28
// - Top to 4G decodes as MMIO
// - Below top is DRAM, except VGA/gaps
// - Low top 0000 is illegal
// - Range way bits pick branches, A6
// - Limits above low top shift by gap
// - Range writes only in allowed states
// - Limit offset by 10H minus top
// - First range lower bound is zero
// - Branch membership uses way-sensitive bit
module mtdc_top
  import mtdc_pkg::*;
#(
  parameter int PRESCALE = DECAY_PRESCALE
)
(
  input wire logic clk, // Core clock, 20 MHz
  input wire logic nrst, // Sync reset, low
  input wire logic cfgWrEn, // Config write strobe
  input wire logic cfgRdEn, // Config read strobe
  input wire logic [7:0] cfgAddr, // Config offset
  input wire logic [31:0] cfgWrData, // Config write data
  output logic [31:0] cfgRdData, // Config read data
  output logic cfgRdValid, // Read data valid
  input wire logic rangeUpdateOk, // Branch in update-safe state
  input wire logic cmdValid, // Command offered
  input wire logic cmdIsWrite, // 1 write, 0 read
  input wire logic [MOD_W-1:0] cmdModule, // Target module
  input wire logic [RANK_W-1:0] cmdRank, // Target rank
  output logic cmdReady, // Command may issue
  input wire logic uncorrErrEvent, // Uncorrectable error pulse
  input wire logic corrErrEvent, // Correctable error pulse
  output logic [ERRCNT_W-1:0] uncorrectableErrorCount, // Count
  output logic [ERRCNT_W-1:0] correctableErrorCount, // Count
  input wire logic decodeValid, // Address to decode
  input wire logic [ADDR_W-1:0] decodeAddr, // Processor address
  input wire logic vgaEnable, // Legacy VGA window on
  input wire logic legacyGapHit, // Address in attribute gap
  output logic isDram, // Decoded as DRAM
  output logic isLowMmio, // Decoded as low MMIO
  output logic rangeHit, // Address in a range
  output logic branchZeroHit, // Branch 0 takes part
  output logic branchOneHit // Branch 1 takes part
);

  typedef struct packed {
    logic [18:0] turnaround;
    logic [31:0] decayThreshold;
    logic [LOWTOP_W-1:0] lowTop;
    logic [NUM_RANGES-1:0][LIMIT_W-1:0] rangeLimit;
    logic [NUM_RANGES-1:0] branchZeroMember;
    logic [NUM_RANGES-1:0] branchOneMember;
    logic [PRESCALE_W-1:0] prescale;
    logic [31:0] period;
    logic [ERRCNT_W-1:0] uerr;
    logic [ERRCNT_W-1:0] cerr;
    logic [31:0] rdData;
    logic rdValid;
    logic dram;
    logic mmio;
    logic hit;
    logic b0;
    logic b1;
    logic [MOD_W-1:0] lastWrMod;
    logic [RANK_W-1:0] lastWrRank;
    logic [MOD_W-1:0] lastRdMod;
    logic [RANK_W-1:0] lastRdRank;
    logic [4:0] sinceWr;
    logic [4:0] sinceRd;
  } mtdc_st_t;

  mtdc_st_t s_reg;
  mtdc_st_t s_next;

  logic [NUM_GAPS-1:0] gapBusy;
  logic [NUM_GAPS-1:0] gapLoad;
  logic [NUM_GAPS-1:0][GAP_W-1:0] gapVal;
  logic [NUM_GAPS-1:0] block;
  logic issue;
  logic tick;
  logic periodHit;
  logic [31:0] periodInc;
  logic [NUM_RANGES:0][8:0] effLimit;
  logic [NUM_RANGES-1:0] rangeMatch;
  logic [8:0] addrSlice;
  logic wayBit;
  logic mmioNow;
  logic vgaNow;
  logic hitNow;
  logic b0Now;
  logic b1Now;

  // ----------------------------------------------------------------
  // Command spacing
  // ----------------------------------------------------------------

  // Spacing values out of the turnaround register
  assign gapVal[GI_WR_RD_OTHER] = {1'b0,
    s_reg.turnaround[WR_RD_OTHER_LSB +: WR_RD_OTHER_W]};
  assign gapVal[GI_RD_WR] = s_reg.turnaround[RD_WR_LSB +: GAP_W];
  assign gapVal[GI_WR_RD_SAME] = s_reg.turnaround[WR_RD_SAME_LSB +: GAP_W];
  assign gapVal[GI_RD_RD_OTHER] = s_reg.turnaround[RD_RD_OTHER_LSB +: GAP_W];
  assign gapVal[GI_WR_WR] = s_reg.turnaround[WR_WR_LSB +: GAP_W];

  // Which timers restart on this command
  assign gapLoad[GI_WR_RD_OTHER] = issue && cmdIsWrite;
  assign gapLoad[GI_RD_WR] = issue && !cmdIsWrite;
  assign gapLoad[GI_WR_RD_SAME] = issue && cmdIsWrite;
  assign gapLoad[GI_RD_RD_OTHER] = issue && !cmdIsWrite;
  assign gapLoad[GI_WR_WR] = issue && cmdIsWrite;

  // One timer per spacing constraint
  generate
    for (genvar g = 0; g < NUM_GAPS; g++)
    begin : gGap
      mtdc_gap_timer uTimer (
        .clk(clk),
        .nrst(nrst),
        .load(gapLoad[g]),
        .loadVal(gapVal[g]),
        .busy(gapBusy[g])
      );
    end
  endgenerate

  // Hold-back terms against the last read and last write
  always_comb
  begin
    block = '0;
    block[GI_WR_RD_OTHER] = !cmdIsWrite && gapBusy[GI_WR_RD_OTHER]
      && cmdModule == s_reg.lastWrMod && cmdRank != s_reg.lastWrRank;
    block[GI_RD_WR] = cmdIsWrite && gapBusy[GI_RD_WR]
      && cmdModule == s_reg.lastRdMod;
    block[GI_WR_RD_SAME] = !cmdIsWrite && gapBusy[GI_WR_RD_SAME]
      && cmdModule == s_reg.lastWrMod && cmdRank == s_reg.lastWrRank;
    block[GI_RD_RD_OTHER] = !cmdIsWrite && gapBusy[GI_RD_RD_OTHER]
      && cmdModule == s_reg.lastRdMod && cmdRank != s_reg.lastRdRank;
    block[GI_WR_WR] = cmdIsWrite && gapBusy[GI_WR_WR]
      && cmdModule == s_reg.lastWrMod;
  end

  assign cmdReady = ~|block;
  assign issue = cmdValid && cmdReady;

  // ----------------------------------------------------------------
  // Error decay timing
  // ----------------------------------------------------------------

  // Prescaler wrap and threshold match
  assign tick = (s_reg.prescale == PRESCALE_W'(PRESCALE - 1));
  assign periodInc = s_reg.period + 32'h00000001;
  assign periodHit = tick && (periodInc == s_reg.decayThreshold);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  assign addrSlice = {1'b0, decodeAddr[35:28]};
  assign wayBit = decodeAddr[WAY_SENSE_BIT];
  assign effLimit[0] = 9'h000;

  // Limits above the low top are raised by the MMIO gap
  generate
    for (genvar r = 0; r < NUM_RANGES; r++)
    begin : gRange
      logic [8:0] lim;
      assign lim = {1'b0, s_reg.rangeLimit[r]};
      assign effLimit[r+1] = (lim <= {5'h00, s_reg.lowTop}) ? lim
        : 9'(lim + GAP_BASE_4G - {5'h00, s_reg.lowTop});
      assign rangeMatch[r] = (addrSlice < effLimit[r+1])
        && (addrSlice >= effLimit[r]);
    end
  endgenerate

  // First matching range chooses the branches
  always_comb
  begin
    hitNow = 1'b0;
    b0Now = 1'b0;
    b1Now = 1'b0;
    for (int r = NUM_RANGES - 1; r >= 0; r--)
    begin
      if (rangeMatch[r])
      begin
        hitNow = 1'b1;
        b1Now = s_reg.branchOneMember[r]
          && (wayBit || !s_reg.branchZeroMember[r]);
        b0Now = s_reg.branchZeroMember[r]
          && (!wayBit || !s_reg.branchOneMember[r]);
      end
    end
  end

  // Low MMIO hole and legacy holes
  assign mmioNow = (decodeAddr[35:32] == 4'h0)
    && (decodeAddr[31:28] >= s_reg.lowTop);
  assign vgaNow = vgaEnable && (decodeAddr[35:VGA_LSB] == VGA_PAGE);

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rdValid = 1'b0;
    // Register writes
    if (cfgWrEn)
    begin
      unique case (cfgAddr)
        OFS_TURNAROUND: s_next.turnaround = cfgWrData[18:0];
        OFS_DECAY: s_next.decayThreshold = cfgWrData;
        OFS_LOWTOP:
        begin
          if (cfgWrData[LOWTOP_LSB +: LOWTOP_W] != LOWTOP_ILLEGAL)
            s_next.lowTop = cfgWrData[LOWTOP_LSB +: LOWTOP_W];
        end
        OFS_RANGE0, OFS_RANGE1, OFS_RANGE2:
        begin
          if (rangeUpdateOk)
          begin
            for (int r = 0; r < NUM_RANGES; r++)
            begin
              if (cfgAddr == OFS_RANGE0 + 8'(4 * r))
              begin
                s_next.rangeLimit[r] = cfgWrData[LIMIT_LSB +: LIMIT_W];
                s_next.branchZeroMember[r] = cfgWrData[BRANCH_ZERO_MEMBER_BIT];
                s_next.branchOneMember[r] = cfgWrData[BRANCH_ONE_MEMBER_BIT];
              end
            end
          end
        end
        default: ;
      endcase
    end
    // Register reads, unmapped offsets read zero
    if (cfgRdEn)
    begin
      s_next.rdValid = 1'b1;
      s_next.rdData = 32'h00000000;
      unique case (cfgAddr)
        OFS_TURNAROUND: s_next.rdData = {13'h0000, s_reg.turnaround};
        OFS_DECAY: s_next.rdData = s_reg.decayThreshold;
        OFS_LOWTOP: s_next.rdData = {16'h0000, s_reg.lowTop, 12'h000};
        OFS_RANGE0, OFS_RANGE1, OFS_RANGE2:
        begin
          for (int r = 0; r < NUM_RANGES; r++)
          begin
            if (cfgAddr == OFS_RANGE0 + 8'(4 * r))
              s_next.rdData = {20'h00000, s_reg.rangeLimit[r], 2'b00,
                s_reg.branchOneMember[r], s_reg.branchZeroMember[r]};
          end
        end
        default: ;
      endcase
    end
    // Prescaler and period counter
    s_next.prescale = tick ? '0 : s_reg.prescale + 15'h0001;
    if (periodHit)
      s_next.period = 32'h00000000;
    else if (tick)
      s_next.period = periodInc;
    // Error counts, increment and decay cancel out
    if (uncorrErrEvent && !(periodHit && s_reg.uerr != '0))
      s_next.uerr = (s_reg.uerr == '1) ? s_reg.uerr : s_reg.uerr + 8'h01;
    else if (!uncorrErrEvent && periodHit && s_reg.uerr != '0)
      s_next.uerr = s_reg.uerr - 8'h01;
    if (corrErrEvent && !(periodHit && s_reg.cerr != '0))
      s_next.cerr = (s_reg.cerr == '1) ? s_reg.cerr : s_reg.cerr + 8'h01;
    else if (!corrErrEvent && periodHit && s_reg.cerr != '0)
      s_next.cerr = s_reg.cerr - 8'h01;
    // Decode result registered
    if (decodeValid)
    begin
      s_next.mmio = mmioNow;
      s_next.dram = !mmioNow && !(vgaNow || legacyGapHit);
      s_next.hit = hitNow && !mmioNow;
      s_next.b0 = b0Now && !mmioNow;
      s_next.b1 = b1Now && !mmioNow;
    end
    // Last command of each kind
    s_next.sinceWr = (s_reg.sinceWr == 5'h1f) ? s_reg.sinceWr : s_reg.sinceWr + 5'h01;
    s_next.sinceRd = (s_reg.sinceRd == 5'h1f) ? s_reg.sinceRd : s_reg.sinceRd + 5'h01;
    if (issue && cmdIsWrite)
    begin
      s_next.lastWrMod = cmdModule;
      s_next.lastWrRank = cmdRank;
      s_next.sinceWr = 5'h01;
    end
    if (issue && !cmdIsWrite)
    begin
      s_next.lastRdMod = cmdModule;
      s_next.lastRdRank = cmdRank;
      s_next.sinceRd = 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.turnaround <= TURNAROUND_RST;
      s_reg.decayThreshold <= DECAY_RST;
      s_reg.lowTop <= LOWTOP_RST;
      s_reg.sinceWr <= 5'h1f;
      s_reg.sinceRd <= 5'h1f;
    end
    else
      s_reg <= s_next;
  end

  // Outputs
  assign cfgRdData = s_reg.rdData;
  assign cfgRdValid = s_reg.rdValid;
  assign uncorrectableErrorCount = s_reg.uerr;
  assign correctableErrorCount = s_reg.cerr;
  assign isDram = s_reg.dram;
  assign isLowMmio = s_reg.mmio;
  assign rangeHit = s_reg.hit;
  assign branchZeroHit = s_reg.b0;
  assign branchOneHit = s_reg.b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_wr_rd_other: assert property (
    issue && !cmdIsWrite && cmdModule == s_reg.lastWrMod
    && cmdRank != s_reg.lastWrRank
    |-> s_reg.sinceWr >= {2'b00, s_reg.turnaround[18:16]})
    else $error("write to read other rank too close");
  a_rd_wr_gap: assert property (
    issue && cmdIsWrite && cmdModule == s_reg.lastRdMod
    |-> s_reg.sinceRd >= {1'b0, s_reg.turnaround[15:12]})
    else $error("read to write too close");
  a_wr_rd_same: assert property (
    issue && !cmdIsWrite && cmdModule == s_reg.lastWrMod
    && cmdRank == s_reg.lastWrRank
    |-> s_reg.sinceWr >= {1'b0, s_reg.turnaround[11:8]})
    else $error("write to read same rank too close");
  a_rd_rd_other: assert property (
    issue && !cmdIsWrite && cmdModule == s_reg.lastRdMod
    && cmdRank != s_reg.lastRdRank
    |-> s_reg.sinceRd >= {1'b0, s_reg.turnaround[7:4]})
    else $error("read to read other rank too close");
  a_wr_wr_gap: assert property (
    issue && cmdIsWrite && cmdModule == s_reg.lastWrMod
    |-> s_reg.sinceWr >= {1'b0, s_reg.turnaround[3:0]})
    else $error("write to write too close");
  a_period_step: assert property (
    !tick ##1 !tick |-> $stable(s_reg.period))
    else $error("period moved without prescaler wrap");
  a_decay_uerr: assert property (
    periodHit && s_reg.uerr != '0 && !uncorrErrEvent
    |=> s_reg.uerr == $past(s_reg.uerr) - 8'h01 && s_reg.period == 32'h0)
    else $error("uncorrectable count not decayed");
  a_lowtop_legal: assert property (
    s_reg.lowTop != LOWTOP_ILLEGAL)
    else $error("low top holds illegal value");
  a_mmio_decode: assert property (
    decodeValid && decodeAddr[35:32] == 4'h0
    && decodeAddr[31:28] >= s_reg.lowTop |=> isLowMmio && !isDram)
    else $error("MMIO hole not decoded");
  a_range_lock: assert property (
    cfgWrEn && !rangeUpdateOk |=> $stable(s_reg.rangeLimit))
    else $error("range changed outside allowed state");

  c_decay_hit: cover property (periodHit);
  c_cmd_held: cover property (cmdValid && !cmdReady ##1 issue);
  c_both_branches: cover property (branchZeroHit ##1 branchOneHit);

endmodule

// ===== tb/mtdc_mem_model.sv
`timescale 1ns/1ps
module mtdc_mem_model
  import mtdc_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic nrst, // Sync reset, low
  input wire logic cmdValid, // Command offered
  input wire logic cmdReady, // Command may issue
  input wire logic cmdIsWrite, // 1 write, 0 read
  input wire logic [MOD_W-1:0] cmdModule, // Target module
  input wire logic [RANK_W-1:0] cmdRank, // Target rank
  output logic [15:0] lastGap, // Edges between last two issues
  output logic [15:0] issueCount // Commands accepted
);
  // ----------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------
  logic [15:0] cycle_reg;
  logic [15:0] lastIssue_reg;

  // Modules take every issued command and log its spacing
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cycle_reg <= 16'h0000;
      lastIssue_reg <= 16'h0000;
      lastGap <= 16'h0000;
      issueCount <= 16'h0000;
    end
    else
    begin
      cycle_reg <= cycle_reg + 16'h0001;
      if (cmdValid && cmdReady)
      begin
        lastGap <= cycle_reg - lastIssue_reg;
        lastIssue_reg <= cycle_reg;
        issueCount <= issueCount + 16'h0001;
      end
    end
  end
endmodule

// ===== tb/tb_mtdc_top.sv
`timescale 1ns/1ps
module tb_mtdc_top;
  import mtdc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and instances
  // ----------------------------------------------------------------
  localparam int PS = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [31:0] cfgWrData = 32'h0;
  logic [31:0] cfgRdData;
  logic cfgRdValid;
  logic rangeUpdateOk = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdIsWrite = 1'b0;
  logic [MOD_W-1:0] cmdModule = '0;
  logic [RANK_W-1:0] cmdRank = '0;
  logic cmdReady;
  logic uncorrErrEvent = 1'b0;
  logic corrErrEvent = 1'b0;
  logic [ERRCNT_W-1:0] uCnt;
  logic [ERRCNT_W-1:0] cCnt;
  logic decodeValid = 1'b0;
  logic [ADDR_W-1:0] decodeAddr = '0;
  logic vgaEnable = 1'b0;
  logic legacyGapHit = 1'b0;
  logic isDram, isLowMmio, rangeHit, branchZeroHit, branchOneHit;
  logic [15:0] memGap;
  logic [15:0] memCount;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  // Core clock, 50 ns period
  always #25 clk = ~clk;

  mtdc_top #(.PRESCALE(PS)) dut_u (.clk(clk), .nrst(nrst), .cfgWrEn(cfgWrEn),
    .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .rangeUpdateOk(rangeUpdateOk), .cmdValid(cmdValid),
    .cmdIsWrite(cmdIsWrite), .cmdModule(cmdModule), .cmdRank(cmdRank), .cmdReady(cmdReady),
    .uncorrErrEvent(uncorrErrEvent), .corrErrEvent(corrErrEvent),
    .uncorrectableErrorCount(uCnt), .correctableErrorCount(cCnt), .decodeValid(decodeValid),
    .decodeAddr(decodeAddr), .vgaEnable(vgaEnable), .legacyGapHit(legacyGapHit),
    .isDram(isDram), .isLowMmio(isLowMmio), .rangeHit(rangeHit),
    .branchZeroHit(branchZeroHit), .branchOneHit(branchOneHit));

  mtdc_mem_model mem_u (.clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdIsWrite(cmdIsWrite), .cmdModule(cmdModule), .cmdRank(cmdRank),
    .lastGap(memGap), .issueCount(memCount));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cfgWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    @(posedge clk);
    cfgWrEn <= 1'b0;
  endtask

  task automatic cfgChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRdEn <= 1'b0;
    @(negedge clk);
    chk("read valid", 32'h1, {31'h0, cfgRdValid});
    chk(nm, exp, cfgRdData);
  endtask

  // Offer one command and hold it until it issues
  task automatic issue(input logic w, input logic [1:0] m, input logic [2:0] r);
    int n;
    cmdValid <= 1'b1;
    cmdIsWrite <= w;
    cmdModule <= m;
    cmdRank <= r;
    n = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask

  task automatic gapTest(input string nm, input logic w1, input logic w2, input logic [1:0] m2,
    input logic [2:0] r2, input int exp);
    repeat (20) @(posedge clk);
    issue(w1, 2'h0, 3'h0);
    issue(w2, m2, r2);
    cmdValid <= 1'b0;
    @(negedge clk);
    chk(nm, exp, {16'h0, memGap});
    $display("test %s done", nm);
  endtask

  task automatic dec(input string nm, input logic [35:0] a, input logic vga, input logic gap,
    input logic [4:0] exp, input logic [4:0] msk);
    @(posedge clk);
    decodeValid <= 1'b1;
    decodeAddr <= a;
    vgaEnable <= vga;
    legacyGapHit <= gap;
    @(posedge clk);
    decodeValid <= 1'b0;
    @(negedge clk);
    chk(nm, {27'h0, exp & msk},
      {27'h0, {isDram, isLowMmio, rangeHit, branchZeroHit, branchOneHit} & msk});
  endtask

  task automatic waitDecay(output int n);
    logic [7:0] prev;
    prev = uCnt;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (uCnt === prev && n < 200);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic resetTest();
    @(negedge clk);
    chk("ready after reset", 32'h1, {31'h0, cmdReady});
    chk("counts after reset", 32'h0, {16'h0, uCnt, cCnt});
    cfgChk("turnaround reset", OFS_TURNAROUND, 32'h0);
    cfgChk("threshold reset", OFS_DECAY, 32'h0);
    cfgChk("low top reset", OFS_LOWTOP, 32'h1000);
    cfgChk("unmapped read", 8'h10, 32'h0);
    $display("test reset done");
  endtask

  task automatic decayTest();
    int n;
    cfgWr(OFS_DECAY, 32'h8);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      uncorrErrEvent <= 1'b1;
      corrErrEvent <= (i == 0); // Only the first pulse is correctable
      @(posedge clk);
      uncorrErrEvent <= 1'b0;
      corrErrEvent <= 1'b0;
    end
    @(negedge clk);
    chk("counts raised", 32'h0301, {16'h0, uCnt, cCnt});
    waitDecay(n);
    chk("first decay", 32'h0200, {16'h0, uCnt, cCnt});
    waitDecay(n);
    chk("decay period", 8 * PS, n);
    chk("zero stays zero", 32'h0100, {16'h0, uCnt, cCnt});
    waitDecay(n);
    chk("decay period", 8 * PS, n);
    repeat (40) @(negedge clk);
    chk("empty counts", 32'h0, {16'h0, uCnt, cCnt});
    $display("test decay done");
  endtask

  task automatic turnTest();
    cfgWr(OFS_TURNAROUND, 32'hfff56743);
    cfgChk("turnaround", OFS_TURNAROUND, 32'h56743);
    gapTest("wr rd other rank", 1'b1, 1'b0, 2'h0, 3'h1, 5);
    gapTest("rd wr", 1'b0, 1'b1, 2'h0, 3'h0, 6);
    gapTest("wr rd same rank", 1'b1, 1'b0, 2'h0, 3'h0, 7);
    gapTest("rd rd other rank", 1'b0, 1'b0, 2'h0, 3'h1, 4);
    gapTest("wr wr", 1'b1, 1'b1, 2'h0, 3'h0, 3);
    gapTest("wr wr other module", 1'b1, 1'b1, 2'h1, 3'h0, 1);
  endtask

  task automatic mapTest();
    cfgWr(OFS_LOWTOP, 32'h00004fff);
    cfgWr(OFS_LOWTOP, 32'h0);
    cfgChk("low top", OFS_LOWTOP, 32'h4000);
    dec("below top", 36'h0_3fff_ffc0, 1'b0, 1'b0, 5'h10, 5'h1f);
    dec("at top", 36'h0_4000_0000, 1'b0, 1'b0, 5'h08, 5'h1f);
    dec("below 4G", 36'h0_ffff_ffff, 1'b0, 1'b0, 5'h08, 5'h1f);
    dec("above 4G", 36'h1_0000_0000, 1'b0, 1'b0, 5'h10, 5'h18);
    dec("vga on", 36'h0_000a_0000, 1'b1, 1'b0, 5'h00, 5'h10);
    dec("vga off", 36'h0_000a_0000, 1'b0, 1'b0, 5'h10, 5'h10);
    dec("attribute gap", 36'h0_0000_1000, 1'b0, 1'b1, 5'h00, 5'h10);
    $display("test map done");
  endtask

  task automatic rangeTest();
    cfgWr(OFS_RANGE0, 32'h23);
    cfgChk("range locked", OFS_RANGE0, 32'h0);
    @(posedge clk);
    rangeUpdateOk <= 1'b1;
    cfgWr(OFS_RANGE0, 32'h23);
    cfgWr(OFS_RANGE1, 32'hfffff06d);
    cfgWr(OFS_RANGE2, 32'h82);
    cfgChk("range0", OFS_RANGE0, 32'h23);
    cfgChk("range1", OFS_RANGE1, 32'h61);
    dec("range0 a6 high", 36'h0_1000_0040, 1'b0, 1'b0, 5'h15, 5'h1f);
    dec("range0 a6 low", 36'h0_1000_0000, 1'b0, 1'b0, 5'h16, 5'h1f);
    dec("range1 shifted", 36'h1_0000_0000, 1'b0, 1'b0, 5'h16, 5'h17);
    dec("range1 top", 36'h1_1000_0040, 1'b0, 1'b0, 5'h16, 5'h17);
    dec("range2", 36'h1_3000_0000, 1'b0, 1'b0, 5'h15, 5'h17);
    dec("no range", 36'h2_0000_0000, 1'b0, 1'b0, 5'h00, 5'h07);
    $display("test range done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    resetTest();
    decayTest();
    turnTest();
    mapTest();
    rangeTest();
    summarize();
  end
endmodule
